// ===== include/csfr_pkg.sv
package csfr_pkg;

   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned WORD_W = 16;
   localparam logic [11:0] STATUS_OFFSET = 12'h000;
   localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h004;
   localparam logic [11:0] IRQ_MASK_OFFSET = 12'h008;

   // ----------------------------------------------------------------
   // Status word field positions
   // ----------------------------------------------------------------
   localparam int unsigned ACC_A_OVF_BIT = 15;
   localparam int unsigned ACC_B_OVF_BIT = 14;
   localparam int unsigned ACC_A_SAT_BIT = 13;
   localparam int unsigned ACC_B_SAT_BIT = 12;
   localparam int unsigned EITHER_OVF_BIT = 11;
   localparam int unsigned EITHER_SAT_BIT = 10;
   localparam int unsigned HW_LOOP_BIT = 9;
   localparam int unsigned HALF_CARRY_BIT = 8;
   localparam int unsigned PRIO_HI_BIT = 7;
   localparam int unsigned PRIO_LO_BIT = 5;
   localparam int unsigned REPEAT_BIT = 4;
   localparam int unsigned NEGATIVE_BIT = 3;
   localparam int unsigned SIGNED_OVF_BIT = 2;
   localparam int unsigned ZERO_BIT = 1;
   localparam int unsigned CARRY_BIT = 0;
   localparam int unsigned PRIO_W = 3;
   localparam logic [PRIO_W-1:0] PRIO_MAX = 3'h7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;

   // ----------------------------------------------------------------
   // Interrupt event bits
   // ----------------------------------------------------------------
   localparam int unsigned IRQ_N = 5;
   localparam int unsigned IRQ_ACC_A_OVF = 0;
   localparam int unsigned IRQ_ACC_B_OVF = 1;
   localparam int unsigned IRQ_ACC_A_SAT = 2;
   localparam int unsigned IRQ_ACC_B_SAT = 3;
   localparam int unsigned IRQ_SIGNED_OVF = 4;
   localparam logic [IRQ_N-1:0] IRQ_RESET = 5'h00;

endpackage : csfr_pkg

// ===== src/csfr_alu_flags.sv
`timescale 1ns/1ps
`default_nettype none

module csfr_alu_flags (
   // Operation
   input wire logic byte_op,
   input wire logic [15:0] operand_a,
   input wire logic [15:0] operand_b,
   input wire logic carry_in,
   // Zero handling
   input wire logic zero_sticky,
   input wire logic zero_prev,
   // Flags
   output logic negative,
   output logic signed_ovf,
   output logic zero,
   output logic carry,
   output logic half_carry
);

   logic [16:0] sum;
   logic msb_a;
   logic msb_b;
   logic msb_r;
   logic res_zero;

   assign sum = {1'b0, operand_a} + {1'b0, operand_b} + {16'h0000, carry_in};
   assign msb_a = byte_op ? operand_a[7] : operand_a[15];
   assign msb_b = byte_op ? operand_b[7] : operand_b[15];
   assign msb_r = byte_op ? sum[7] : sum[15];
   assign res_zero = byte_op ? (sum[7:0] == 8'h00) : (sum[15:0] == 16'h0000);

   assign negative = msb_r;
   assign signed_ovf = (msb_a == msb_b) && (msb_r != msb_a);
   // Sticky mode only ever clears zero on a non-zero result
   assign zero = zero_sticky ? (zero_prev & res_zero) : res_zero;
   // Carry out of the top bit: carry into bit 8 of the sum for bytes, bit 16 of the sum for words
   assign carry = byte_op ? (operand_a[8] ^ operand_b[8] ^ sum[8]) : sum[16];
   // Carry out of the 4th bit for bytes, the 8th bit for words
   assign half_carry = byte_op ? (operand_a[4] ^ operand_b[4] ^ sum[4])
                               : (operand_a[8] ^ operand_b[8] ^ sum[8]);

endmodule : csfr_alu_flags

`default_nettype wire

// ===== src/csfr_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module csfr_irq_ctrl #(
   parameter int unsigned N = csfr_pkg::IRQ_N
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Events
   input wire logic [N-1:0] event_set,
   // Software access
   input wire logic clear_we,
   input wire logic [N-1:0] clear_data,
   input wire logic mask_we,
   input wire logic [N-1:0] mask_data,
   // State
   output logic [N-1:0] status,
   output logic [N-1:0] mask,
   output logic irq
);

   logic [N-1:0] status_reg;
   logic [N-1:0] mask_reg;

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= csfr_pkg::IRQ_RESET;
      end else begin
         status_reg <= (status_reg & ~(clear_we ? clear_data : '0)) | event_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= csfr_pkg::IRQ_RESET;
      end else if (mask_we) begin
         mask_reg <= mask_data;
      end
   end

   assign status = status_reg;
   assign mask = mask_reg;
   assign irq = |(status_reg & mask_reg);

endmodule : csfr_irq_ctrl

`default_nettype wire

// ===== src/csfr_status_reg.sv
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Accumulator A overflow follows engine, bit 15
// - Accumulator B overflow follows engine, bit 14
// - Accumulator A saturation sticky in bit 13
// - Accumulator B saturation sticky in bit 12
// - Bit 11 ORs overflows; clear only
// - Bit 10 ORs saturations; clear only
// - Bit 9 shows DO loop, read-only
// - Bit 8 half carry, byte/word position
// - Writes change sticky bits; bit 10 clears both
// - Top bit extends priority; set disables interrupts
// - Bits 7:5 hold priority level 0-7
// - Bit 4 shows REPEAT loop, read-only
// - Bit 3 negative, bit 2 signed overflow
// - Zero clears on non-zero; carry from MSb
module csfr_status_reg #(
   parameter int unsigned ADDR_W = 12
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Accumulator engine
   input wire logic dsp_flags_update,
   input wire logic acc_a_overflow,
   input wire logic acc_b_overflow,
   input wire logic acc_a_saturate,
   input wire logic acc_b_saturate,
   // Loop control
   input wire logic do_loop_running,
   input wire logic repeat_loop_running,
   // Integer ALU
   input wire logic alu_flags_update,
   input wire logic alu_byte_op,
   input wire logic [15:0] alu_operand_a,
   input wire logic [15:0] alu_operand_b,
   input wire logic alu_carry_in,
   input wire logic alu_zero_sticky,
   // Priority
   input wire logic priority_level_top_bit,
   input wire logic priority_write_lock,
   // Status outputs
   output logic [15:0] cpu_status_word,
   output logic [3:0] cpu_priority_level,
   output logic user_irq_disabled,
   output logic irq
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [11:0] offset);
      addr_is = (addr == offset[ADDR_W-1:0]);
   endfunction : addr_is

   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic access;
   logic fire;
   logic wr_fire;
   logic hit_status;
   logic hit_irq_status;
   logic hit_irq_mask;
   logic mapped;
   logic wr_lo;
   logic wr_hi;

   assign access = psel && penable;
   assign fire = access && pready_reg;
   assign wr_fire = fire && pwrite;
   assign hit_status = addr_is(paddr, csfr_pkg::STATUS_OFFSET);
   assign hit_irq_status = addr_is(paddr, csfr_pkg::IRQ_STATUS_OFFSET);
   assign hit_irq_mask = addr_is(paddr, csfr_pkg::IRQ_MASK_OFFSET);
   assign mapped = hit_status || hit_irq_status || hit_irq_mask;
   assign wr_lo = wr_fire && hit_status && pstrb[0];
   assign wr_hi = wr_fire && hit_status && pstrb[1];

   // ----------------------------------------------------------------
   // Status word storage
   // ----------------------------------------------------------------
   logic acc_a_overflow_flag_reg;
   logic acc_b_overflow_flag_reg;
   logic acc_a_saturation_sticky_reg;
   logic acc_b_saturation_sticky_reg;
   logic hw_loop_active_reg;
   logic repeat_loop_active_reg;
   logic half_carry_flag_reg;
   logic [csfr_pkg::PRIO_W-1:0] priority_level_field_reg;
   logic negative_flag_reg;
   logic signed_overflow_flag_reg;
   logic zero_flag_reg;
   logic carry_flag_reg;
   logic either_acc_overflow;
   logic either_acc_saturation;

   logic alu_n;
   logic alu_ov;
   logic alu_z;
   logic alu_c;
   logic alu_dc;

   csfr_alu_flags u_alu_flags (
      .byte_op(alu_byte_op),
      .operand_a(alu_operand_a),
      .operand_b(alu_operand_b),
      .carry_in(alu_carry_in),
      .zero_sticky(alu_zero_sticky),
      .zero_prev(zero_flag_reg),
      .negative(alu_n),
      .signed_ovf(alu_ov),
      .zero(alu_z),
      .carry(alu_c),
      .half_carry(alu_dc)
   );

   // Overflow flags track the engine; a write of zero to bit 11 clears both
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_a_overflow_flag_reg <= 1'b0;
         acc_b_overflow_flag_reg <= 1'b0;
      end else if (dsp_flags_update) begin
         acc_a_overflow_flag_reg <= acc_a_overflow;
         acc_b_overflow_flag_reg <= acc_b_overflow;
      end else if (wr_hi) begin
         acc_a_overflow_flag_reg <= pwdata[csfr_pkg::ACC_A_OVF_BIT]
                                    & pwdata[csfr_pkg::EITHER_OVF_BIT];
         acc_b_overflow_flag_reg <= pwdata[csfr_pkg::ACC_B_OVF_BIT]
                                    & pwdata[csfr_pkg::EITHER_OVF_BIT];
      end
   end

   // Saturation is sticky; a new saturation wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_a_saturation_sticky_reg <= 1'b0;
      end else if (dsp_flags_update && acc_a_saturate) begin
         acc_a_saturation_sticky_reg <= 1'b1;
      end else if (wr_hi) begin
         acc_a_saturation_sticky_reg <= pwdata[csfr_pkg::ACC_A_SAT_BIT]
                                        & pwdata[csfr_pkg::EITHER_SAT_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_b_saturation_sticky_reg <= 1'b0;
      end else if (dsp_flags_update && acc_b_saturate) begin
         acc_b_saturation_sticky_reg <= 1'b1;
      end else if (wr_hi) begin
         acc_b_saturation_sticky_reg <= pwdata[csfr_pkg::ACC_B_SAT_BIT]
                                        & pwdata[csfr_pkg::EITHER_SAT_BIT];
      end
   end

   assign either_acc_overflow = acc_a_overflow_flag_reg | acc_b_overflow_flag_reg;
   assign either_acc_saturation = acc_a_saturation_sticky_reg
                                  | acc_b_saturation_sticky_reg;

   // Loop activity is sampled every cycle; write data never reaches it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hw_loop_active_reg <= 1'b0;
         repeat_loop_active_reg <= 1'b0;
      end else begin
         hw_loop_active_reg <= do_loop_running;
         repeat_loop_active_reg <= repeat_loop_running;
      end
   end

   // ALU flags: an ALU update in the same cycle as a write takes the flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_carry_flag_reg <= 1'b0;
      end else if (alu_flags_update) begin
         half_carry_flag_reg <= alu_dc;
      end else if (wr_hi) begin
         half_carry_flag_reg <= pwdata[csfr_pkg::HALF_CARRY_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         negative_flag_reg <= 1'b0;
         signed_overflow_flag_reg <= 1'b0;
         zero_flag_reg <= 1'b0;
         carry_flag_reg <= 1'b0;
      end else if (alu_flags_update) begin
         negative_flag_reg <= alu_n;
         signed_overflow_flag_reg <= alu_ov;
         zero_flag_reg <= alu_z;
         carry_flag_reg <= alu_c;
      end else if (wr_lo) begin
         negative_flag_reg <= pwdata[csfr_pkg::NEGATIVE_BIT];
         signed_overflow_flag_reg <= pwdata[csfr_pkg::SIGNED_OVF_BIT];
         zero_flag_reg <= pwdata[csfr_pkg::ZERO_BIT];
         carry_flag_reg <= pwdata[csfr_pkg::CARRY_BIT];
      end
   end

   // Priority field is software state unless the lock input holds it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         priority_level_field_reg <= csfr_pkg::PRIO_RESET;
      end else if (wr_lo && !priority_write_lock) begin
         priority_level_field_reg <= pwdata[csfr_pkg::PRIO_HI_BIT:csfr_pkg::PRIO_LO_BIT];
      end
   end

   assign cpu_status_word = {acc_a_overflow_flag_reg,
                             acc_b_overflow_flag_reg,
                             acc_a_saturation_sticky_reg,
                             acc_b_saturation_sticky_reg,
                             either_acc_overflow,
                             either_acc_saturation,
                             hw_loop_active_reg,
                             half_carry_flag_reg,
                             priority_level_field_reg,
                             repeat_loop_active_reg,
                             negative_flag_reg,
                             signed_overflow_flag_reg,
                             zero_flag_reg,
                             carry_flag_reg};

   // Four-bit level: top bit adds eight and shuts out user interrupts
   assign cpu_priority_level = {priority_level_top_bit, priority_level_field_reg};
   assign user_irq_disabled = priority_level_top_bit
                              || (priority_level_field_reg == csfr_pkg::PRIO_MAX);

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   logic [csfr_pkg::IRQ_N-1:0] irq_events;
   logic [csfr_pkg::IRQ_N-1:0] irq_status;
   logic [csfr_pkg::IRQ_N-1:0] irq_mask;

   // Accumulator events fire on a flag's new assertion only; signed overflow fires on every ALU update that sets it
   always_comb begin
      irq_events = '0;
      irq_events[csfr_pkg::IRQ_ACC_A_OVF] = dsp_flags_update && acc_a_overflow
                                           && !acc_a_overflow_flag_reg;
      irq_events[csfr_pkg::IRQ_ACC_B_OVF] = dsp_flags_update && acc_b_overflow
                                           && !acc_b_overflow_flag_reg;
      irq_events[csfr_pkg::IRQ_ACC_A_SAT] = dsp_flags_update && acc_a_saturate
                                           && !acc_a_saturation_sticky_reg;
      irq_events[csfr_pkg::IRQ_ACC_B_SAT] = dsp_flags_update && acc_b_saturate
                                           && !acc_b_saturation_sticky_reg;
      irq_events[csfr_pkg::IRQ_SIGNED_OVF] = alu_flags_update && alu_ov;
   end

   csfr_irq_ctrl #(
      .N(csfr_pkg::IRQ_N)
   ) u_irq_ctrl (
      .pclk(pclk),
      .presetn(presetn),
      .event_set(irq_events),
      .clear_we(wr_fire && hit_irq_status && pstrb[0]),
      .clear_data(pwdata[csfr_pkg::IRQ_N-1:0]),
      .mask_we(wr_fire && hit_irq_mask && pstrb[0]),
      .mask_data(pwdata[csfr_pkg::IRQ_N-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   // ----------------------------------------------------------------
   // APB response: one wait state, read data captured from flops
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= access && !pready_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= access && !pready_reg && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (access && !pready_reg && !pwrite) begin
         if (hit_status) begin
            prdata_reg <= {16'h0000, cpu_status_word};
         end else if (hit_irq_status) begin
            prdata_reg <= {27'h0000000, irq_status};
         end else if (hit_irq_mask) begin
            prdata_reg <= {27'h0000000, irq_mask};
         end else begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata = prdata_reg;

endmodule : csfr_status_reg

`default_nettype wire

// ===== testbench/csfr_status_reg_checker.sv
`timescale 1ns/1ps
`default_nettype none

module csfr_status_reg_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   // Flag sources
   input wire logic dsp_flags_update,
   input wire logic acc_a_overflow,
   input wire logic acc_b_overflow,
   input wire logic acc_a_saturate,
   input wire logic acc_b_saturate,
   input wire logic do_loop_running,
   input wire logic repeat_loop_running,
   input wire logic alu_flags_update,
   input wire logic alu_byte_op,
   input wire logic [15:0] alu_operand_a,
   input wire logic [15:0] alu_operand_b,
   input wire logic alu_carry_in,
   input wire logic priority_level_top_bit,
   // Status
   input wire logic [15:0] cpu_status_word,
   input wire logic [3:0] cpu_priority_level,
   input wire logic user_irq_disabled
);
   logic [16:0] sum;
   logic [8:0] lo;
   logic c_exp;
   logic wr_done;
   assign sum = {1'b0, alu_operand_a} + {1'b0, alu_operand_b} + {16'h0, alu_carry_in};
   assign lo = {1'b0, alu_operand_a[7:0]} + {1'b0, alu_operand_b[7:0]} + {8'h0, alu_carry_in};
   assign c_exp = alu_byte_op ? lo[8] : sum[16];
   assign wr_done = psel && penable && pready && pwrite;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_ACC_A_OVF: assert property (dsp_flags_update |=> cpu_status_word[15] == $past(acc_a_overflow))
      else $error("acc A overflow flag wrong");
   AST_ACC_B_OVF: assert property (dsp_flags_update |=> cpu_status_word[14] == $past(acc_b_overflow))
      else $error("acc B overflow flag wrong");
   AST_SAT_A_SET: assert property (dsp_flags_update && acc_a_saturate |=> cpu_status_word[13])
      else $error("acc A saturation not set");
   AST_SAT_B_SET: assert property (dsp_flags_update && acc_b_saturate |=> cpu_status_word[12])
      else $error("acc B saturation not set");
   AST_SAT_HOLD: assert property (!wr_done |=> $past(cpu_status_word[13:12]) ==
      (cpu_status_word[13:12] & $past(cpu_status_word[13:12]))) else $error("sticky bit lost");
   AST_OVF_OR: assert property (cpu_status_word[11] == (cpu_status_word[15] | cpu_status_word[14]))
      else $error("combined overflow wrong");
   AST_SAT_OR: assert property (cpu_status_word[10] == (cpu_status_word[13] | cpu_status_word[12]))
      else $error("combined saturation wrong");
   AST_DO_LOOP: assert property (cpu_status_word[9] == $past(do_loop_running))
      else $error("loop active bit wrong");
   AST_REP_LOOP: assert property (cpu_status_word[4] == $past(repeat_loop_running))
      else $error("repeat active bit wrong");
   AST_ALU_CARRY: assert property (alu_flags_update |=> cpu_status_word[0] == $past(c_exp))
      else $error("carry flag wrong");
   AST_PRIO_LEVEL: assert property (cpu_priority_level == {priority_level_top_bit, cpu_status_word[7:5]})
      else $error("priority level wrong");
   AST_USER_DIS: assert property (user_irq_disabled ==
      (priority_level_top_bit || cpu_status_word[7:5] == 3'h7)) else $error("irq disable wrong");
   AST_APB_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("apb wait state wrong");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule : csfr_status_reg_checker

bind csfr_status_reg csfr_status_reg_checker u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .dsp_flags_update(dsp_flags_update),
   .acc_a_overflow(acc_a_overflow), .acc_b_overflow(acc_b_overflow),
   .acc_a_saturate(acc_a_saturate), .acc_b_saturate(acc_b_saturate),
   .do_loop_running(do_loop_running), .repeat_loop_running(repeat_loop_running),
   .alu_flags_update(alu_flags_update), .alu_byte_op(alu_byte_op),
   .alu_operand_a(alu_operand_a), .alu_operand_b(alu_operand_b), .alu_carry_in(alu_carry_in),
   .priority_level_top_bit(priority_level_top_bit), .cpu_status_word(cpu_status_word),
   .cpu_priority_level(cpu_priority_level), .user_irq_disabled(user_irq_disabled));

`default_nettype wire

// ===== testbench/csfr_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

module csfr_engine_model (
   // Clock
   input wire logic pclk,
   // Accumulator engine
   output logic dsp_flags_update,
   output logic [3:0] acc_flags,
   // Loop control
   output logic do_loop_running,
   output logic repeat_loop_running,
   // Integer ALU
   output logic alu_flags_update,
   output logic alu_byte_op,
   output logic [15:0] alu_operand_a,
   output logic [15:0] alu_operand_b,
   output logic alu_carry_in
);
   initial begin
      {dsp_flags_update, acc_flags, do_loop_running, repeat_loop_running} = 8'h00;
      {alu_flags_update, alu_byte_op, alu_carry_in} = 3'h0;
      {alu_operand_a, alu_operand_b} = 32'h0;
   end

   // Qualified values are inverted once the update pulse ends
   task dsp(input logic [3:0] f);
      @(posedge pclk);
      dsp_flags_update <= 1'b1;
      acc_flags <= f;
      @(posedge pclk);
      dsp_flags_update <= 1'b0;
      acc_flags <= ~f;
   endtask : dsp

   task alu(input logic b, input logic [15:0] x, input logic [15:0] y, input logic c);
      @(posedge pclk);
      alu_flags_update <= 1'b1;
      {alu_byte_op, alu_operand_a, alu_operand_b, alu_carry_in} <= {b, x, y, c};
      @(posedge pclk);
      alu_flags_update <= 1'b0;
      {alu_byte_op, alu_operand_a, alu_operand_b, alu_carry_in} <= ~{b, x, y, c};
   endtask : alu

   task loops(input logic d, input logic r);
      @(posedge pclk);
      do_loop_running <= d;
      repeat_loop_running <= r;
   endtask : loops
endmodule : csfr_engine_model

`default_nettype wire

// ===== testbench/cpu_status_flag_register_test.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_status_flag_register_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic top_bit = 1'b0, zs = 1'b0, lk = 1'b0;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, rerr, dsp_up, do_run, rep_run, alu_up, bo, cin, dis, irq;
   logic [3:0] acc, level;
   logic [15:0] opa, opb, word;
   int errors = 0;
   int comparisons = 0;
   logic [15:0] ta [5] = '{16'h7fff, 16'hffff, 16'h000f, 16'h0080, 16'h1234};
   logic [15:0] tb [5] = '{16'h0001, 16'h0001, 16'h0001, 16'h0080, 16'hedcb};
   logic [4:0] tbyte = 5'b01100;
   logic [4:0] tcin = 5'b10000;

   always #5 pclk = ~pclk;

   csfr_status_reg #(.ADDR_W(12)) uut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dsp_flags_update(dsp_up), .acc_a_overflow(acc[3]),
      .acc_b_overflow(acc[2]), .acc_a_saturate(acc[1]), .acc_b_saturate(acc[0]),
      .do_loop_running(do_run), .repeat_loop_running(rep_run), .alu_flags_update(alu_up),
      .alu_byte_op(bo), .alu_operand_a(opa), .alu_operand_b(opb), .alu_carry_in(cin),
      .alu_zero_sticky(zs), .priority_level_top_bit(top_bit), .priority_write_lock(lk),
      .cpu_status_word(word), .cpu_priority_level(level), .user_irq_disabled(dis), .irq(irq));

   csfr_engine_model em (
      .pclk(pclk), .dsp_flags_update(dsp_up), .acc_flags(acc), .do_loop_running(do_run),
      .repeat_loop_running(rep_run), .alu_flags_update(alu_up), .alu_byte_op(bo),
      .alu_operand_a(opa), .alu_operand_b(opb), .alu_carry_in(cin));

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 20) errors++;
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask : wr

   task rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask : rd

   task check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   function automatic logic [15:0] alu_exp(logic b, logic [15:0] x, logic [15:0] y, logic c);
      logic [16:0] s;
      logic [8:0] l;
      logic [4:0] h;
      s = x + y + c;
      l = x[7:0] + y[7:0] + c;
      h = x[3:0] + y[3:0] + c;
      if (b) return {7'h0, h[4], 4'h0, l[7], x[7] == y[7] && l[7] != x[7], l[7:0] == 0, l[8]};
      return {7'h0, l[8], 4'h0, s[15], x[15] == y[15] && s[15] != x[15], s[15:0] == 0, s[16]};
   endfunction : alu_exp

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_ovf;
      rd(12'h000);
      check(rdata, 32'h0);
      em.dsp(4'h8);
      rd(12'h000);
      check(rdata, 32'h8800);
      em.dsp(4'h4);
      rd(12'h000);
      check(rdata, 32'h4800);
      wr(12'h000, 32'h4000);
      rd(12'h000);
      check(rdata, 32'h0);
   endtask : t_ovf

   task t_sat;
      em.dsp(4'h2);
      em.dsp(4'h0);
      rd(12'h000);
      check(rdata, 32'h2400);
      em.dsp(4'h1);
      rd(12'h000);
      check(rdata, 32'h3400);
      wr(12'h000, 32'h3000);
      rd(12'h000);
      check(rdata, 32'h0);
      wr(12'h000, 32'h1400);
      rd(12'h000);
      check(rdata, 32'h1400);
      wr(12'h000, 32'h0);
   endtask : t_sat

   task t_loop;
      em.loops(1'b1, 1'b0);
      wr(12'h000, 32'h0);
      rd(12'h000);
      check(rdata, 32'h02e0);
      em.loops(1'b0, 1'b1);
      wr(12'h000, 32'h0200);
      rd(12'h000);
      check(rdata, 32'h00f0);
      em.loops(1'b0, 1'b0);
      rd(12'h000);
      check(rdata, 32'he0);
   endtask : t_loop

   task t_alu;
      for (int i = 0; i < 5; i++) begin
         zs <= i == 3;
         em.alu(tbyte[i], ta[i], tb[i], tcin[i]);
         rd(12'h000);
         check(rdata, {16'h0, alu_exp(tbyte[i], ta[i], tb[i], tcin[i])}
               ^ {zs, 1'b0});
      end
      wr(12'h000, 32'h0);
   endtask : t_alu

   task t_prio;
      for (int i = 0; i < 16; i++) begin
         top_bit <= i[3];
         apb(1'b1, 12'h000, 32'(i[2:0]) << 5, 4'h1);
         rd(12'h000);
         check(rdata, {24'h0, i[2:0], 5'h0});
         check(32'(level), 32'(i[3:0]));
         check(32'(dis), 32'(i[3] || i[2:0] == 3'h7));
      end
      {top_bit, lk} <= 2'b01;
   endtask : t_prio

   task t_irq;
      rd(12'h004);
      check(rdata, 32'h1f);
      check(32'(irq), 32'h0);
      wr(12'h008, 32'h11);
      rd(12'h008);
      check(rdata, 32'h11);
      check(32'(irq), 32'h1);
      wr(12'h004, 32'h11);
      rd(12'h004);
      check(rdata, 32'h0e);
      check(32'(irq), 32'h0);
      rd(12'h00c);
      check(32'(rerr), 32'h1);
      check(rdata, 32'h0);
   endtask : t_irq

   task stop_test;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_ovf();
      t_sat();
      t_alu();
      t_prio();
      t_loop();
      t_irq();
      stop_test();
   end

   initial begin
      #100000;
      errors++;
      stop_test();
   end
endmodule : cpu_status_flag_register_test

`default_nettype wire
